// ==== hw/spp_pkg.sv ====
package spp_pkg;

    // Port width and register map
    localparam int          SPP_WIDTH     = 16;
    localparam logic [7:0]  SPP_DIR_OFS   = 8'h00;
    localparam logic [7:0]  SPP_LATCH_OFS = 8'h04;
    localparam logic [7:0]  SPP_PIN_OFS   = 8'h08;

    // Reset values: all pins input, latch clear
    localparam logic [SPP_WIDTH-1:0] SPP_DIR_RST   = 16'hFFFF;
    localparam logic [SPP_WIDTH-1:0] SPP_LATCH_RST = 16'h0000;

    // Register select produced by the address decoder
    typedef enum logic [1:0] {
        SPP_SEL_DIR   = 2'h0,
        SPP_SEL_LATCH = 2'h1,
        SPP_SEL_PIN   = 2'h3,
        SPP_SEL_NONE  = 2'h2
    } spp_sel_t;

    // Bus slave states, Gray along idle -> ack
    typedef enum logic [1:0] {
        SPP_ST_IDLE = 2'h0,
        SPP_ST_ACK  = 2'h1
    } spp_bus_st_t;

    // Bundle from the peripherals sharing the pins
    typedef struct packed {
        logic [SPP_WIDTH-1:0] en;
        logic [SPP_WIDTH-1:0] drive;
        logic [SPP_WIDTH-1:0] dout;
    } spp_periph_t;

    // Bundle toward the pad ring
    typedef struct packed {
        logic [SPP_WIDTH-1:0] dout;
        logic [SPP_WIDTH-1:0] oe;
    } spp_pad_t;

    // Whole state of the port
    typedef struct packed {
        logic [SPP_WIDTH-1:0] dir_r;
        logic [SPP_WIDTH-1:0] latch_r;
        logic [SPP_WIDTH-1:0] sync1_r;
        logic [SPP_WIDTH-1:0] sync2_r;
        spp_pad_t             pad_r;
        logic [SPP_WIDTH-1:0] periph_in_r;
        logic [31:0]          prdata_r;
        logic                 pready_r;
        logic                 pslverr_r;
        spp_bus_st_t          st_r;
    } spp_state_t;

endpackage

// ==== hw/spp_port.sv ====
`timescale 1ns/1ps
// How it works
// - Peripheral outranks the port on shared pins
// - Per-pin muxes pick data and enable source
// - Port output never loops into peripheral input
// - Driving peripheral disables the port driver on shared pins only
// - Pin level stays readable under peripheral ownership
// - Enabled but idle peripheral lets port drive
// - Direction bit one means input
// - Reset makes every pin an input
// - Latch register reads and writes the latch
// - Pin register reads pins, writes the latch
// - Unimplemented bits read zero and stay off
// - Input-only sharing leaves the port sole driver
module spp_port
    import spp_pkg::*;
#(
    parameter logic [SPP_WIDTH-1:0] IMPL_MASK   = 16'hFFFF,
    parameter logic [SPP_WIDTH-1:0] SHARED_MASK = 16'hFFFF
) (
    // Clock, reset, enable
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Peripherals sharing the pins
    input  wire spp_periph_t          periph,
    output logic      [SPP_WIDTH-1:0] periph_in,
    // Pads
    input  wire logic [SPP_WIDTH-1:0] pin_in,
    output spp_pad_t                  pad
);

    spp_state_t s_r;
    spp_state_t s_nxt;

    // Address decode, shared by the read and write paths
    function automatic spp_sel_t decode(input logic [7:0] a);
        case (a)
            SPP_DIR_OFS:   decode = SPP_SEL_DIR;
            SPP_LATCH_OFS: decode = SPP_SEL_LATCH;
            SPP_PIN_OFS:   decode = SPP_SEL_PIN;
            default:       decode = SPP_SEL_NONE;
        endcase
    endfunction

    // Pins a peripheral currently owns; input-only sharers never own
    function automatic logic [SPP_WIDTH-1:0] owned(input spp_periph_t p);
        owned = p.en & p.drive & SHARED_MASK & IMPL_MASK;
    endfunction

    logic [SPP_WIDTH-1:0] own;
    logic [SPP_WIDTH-1:0] port_oe;
    logic [SPP_WIDTH-1:0] wdata;
    spp_sel_t             sel;
    logic                 access;

    // Next-state logic
    always_comb begin
        s_nxt   = s_r;
        own     = owned(periph);
        sel     = decode(paddr);
        wdata   = pwdata[SPP_WIDTH-1:0] & IMPL_MASK;
        access  = psel & penable;
        port_oe = ~s_r.dir_r & IMPL_MASK;

        // Two-stage synchroniser; only stage two is used downstream
        s_nxt.sync1_r = pin_in;
        s_nxt.sync2_r = s_r.sync1_r;

        // Output muxes: peripheral data and enable first, else the port
        s_nxt.pad_r.dout = (own & periph.dout) | (~own & s_r.latch_r & IMPL_MASK);
        s_nxt.pad_r.oe   = own | (~own & port_oe);

        // Peripheral sees the pin only when the port is not driving it
        s_nxt.periph_in_r = s_r.sync2_r & ~(~own & port_oe) & IMPL_MASK;

        // Bus slave: one wait state, answer from a register
        case (s_r.st_r)
            SPP_ST_IDLE: begin
                s_nxt.pready_r  = 1'b0;
                s_nxt.pslverr_r = 1'b0;
                if (access) begin
                    s_nxt.st_r      = SPP_ST_ACK;
                    s_nxt.pready_r  = 1'b1;
                    s_nxt.pslverr_r = (sel == SPP_SEL_NONE);
                    s_nxt.prdata_r  = 32'h0000_0000;
                    if (!pwrite) begin
                        case (sel)
                            SPP_SEL_DIR:   s_nxt.prdata_r[SPP_WIDTH-1:0] =
                                               s_r.dir_r & IMPL_MASK;
                            SPP_SEL_LATCH: s_nxt.prdata_r[SPP_WIDTH-1:0] =
                                               s_r.latch_r & IMPL_MASK;
                            SPP_SEL_PIN:   s_nxt.prdata_r[SPP_WIDTH-1:0] =
                                               s_r.sync2_r & IMPL_MASK;
                            default:       s_nxt.prdata_r = 32'h0000_0000;
                        endcase
                    end
                end
            end
            SPP_ST_ACK: begin
                // Write lands on the edge where the master sees pready
                if (access && pwrite) begin
                    case (sel)
                        SPP_SEL_DIR:   s_nxt.dir_r = wdata | ~IMPL_MASK;
                        SPP_SEL_LATCH: s_nxt.latch_r = wdata;
                        SPP_SEL_PIN:   s_nxt.latch_r = wdata;
                        default:       s_nxt.latch_r = s_r.latch_r;
                    endcase
                end
                s_nxt.st_r      = SPP_ST_IDLE;
                s_nxt.pready_r  = 1'b0;
                s_nxt.pslverr_r = 1'b0;
            end
            default: begin
                s_nxt.st_r     = SPP_ST_IDLE;
                s_nxt.pready_r = 1'b0;
            end
        endcase
    end

    // State register; unimplemented direction bits held as inputs
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_r.dir_r       <= SPP_DIR_RST;
            s_r.latch_r     <= SPP_LATCH_RST;
            s_r.sync1_r     <= '0;
            s_r.sync2_r     <= '0;
            s_r.pad_r       <= '0;
            s_r.periph_in_r <= '0;
            s_r.prdata_r    <= 32'h0000_0000;
            s_r.pready_r    <= 1'b0;
            s_r.pslverr_r   <= 1'b0;
            s_r.st_r        <= SPP_ST_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign prdata    = s_r.prdata_r;
    assign pready    = s_r.pready_r;
    assign pslverr   = s_r.pslverr_r;
    assign periph_in = s_r.periph_in_r;
    assign pad       = s_r.pad_r;

endmodule // spp_port

// ==== verif/spp_far_model.sv ====
`timescale 1ns/1ps
module spp_far_model
    import spp_pkg::*;
(
    // Clock and bench commands
    input  wire logic                 mclk,
    input  wire logic [SPP_WIDTH-1:0] drv,
    input  wire logic [SPP_WIDTH-1:0] ext,
    // Block side
    input  wire spp_pad_t             pad,
    output spp_periph_t               periph,
    output logic      [SPP_WIDTH-1:0] pin_in
);
    // Bits 7:4 stay enabled but idle; data toggles so stale values show
    initial periph = '0;
    always @(posedge mclk) begin
        periph <= '{drv | 16'h00F0, drv, ~periph.dout};
    end
    // Pad wire: block level where it drives, else outside level
    assign pin_in = (pad.oe & pad.dout) | (~pad.oe & ext);
endmodule // spp_far_model

// ==== verif/spp_checker.sv ====
`timescale 1ns/1ps
module spp_checker
    import spp_pkg::*;
#(
    parameter logic [SPP_WIDTH-1:0] IMPL_MASK   = 16'hFFFF,
    parameter logic [SPP_WIDTH-1:0] SHARED_MASK = 16'hFFFF
) (
    // Watched ports
    input wire logic                 mclk, resetn, ce, psel, penable, pready, pslverr,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic [SPP_WIDTH-1:0] periph_in, pin_in,
    input wire spp_periph_t          periph,
    input wire spp_pad_t             pad
);
    logic                 rdy;
    logic [SPP_WIDTH-1:0] own;
    // One live cycle first, so a one-step $past never reaches into reset
    always_ff @(posedge mclk) rdy <= resetn & ce;
    assign own = periph.en & periph.drive & SHARED_MASK & IMPL_MASK;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn || !rdy);
    property p_oe; (pad.oe & $past(own)) == $past(own); endproperty
    a_oe: assert property (p_oe) else $error("owned pin undriven");
    property p_do; ((pad.dout ^ $past(periph.dout)) & $past(own)) == 0; endproperty
    a_do: assert property (p_do) else $error("owned pin data");
    property p_imp; ((pad.oe | pad.dout | periph_in) & ~IMPL_MASK) == 0; endproperty
    a_imp: assert property (p_imp) else $error("absent bit active");
    property p_loop; (periph_in & pad.oe & ~$past(own)) == 0; endproperty
    a_loop: assert property (p_loop) else $error("port loops to peripheral");
    property p_ack; psel && penable && !pready |=> pready ##1 !pready; endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing");
    property p_err; pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}); endproperty
    a_err: assert property (p_err) else $error("bus error flag");
    property p_hi; pready |-> (prdata >> (pslverr ? 0 : 16)) == 0; endproperty
    a_hi: assert property (p_hi) else $error("read data bits");
    property p_pass; ((periph_in ^ $past(pin_in, 3)) & $past(own) & $past(own, 2)) == 0; endproperty
    a_pass: assert property (p_pass) else $error("owned pin level");
    cover property (pslverr);
    cover property ($past(own) != 0);
    cover property (pready && !pslverr);
endmodule // spp_checker
bind spp_port spp_checker #(.IMPL_MASK(IMPL_MASK), .SHARED_MASK(SHARED_MASK)) chk (.mclk(mclk),
    .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .prdata(prdata), .periph_in(periph_in), .pin_in(pin_in), .periph(periph),
    .pad(pad));

// ==== verif/tb_shared_pin_parallel_port.sv ====
`timescale 1ns/1ps
module tb_shared_pin_parallel_port;
    import spp_pkg::*;
    logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] drv = 0, ext = 0, periph_in, pin_in;
    spp_periph_t periph;
    spp_pad_t    pad;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    spp_port #(.IMPL_MASK(16'h7FFF), .SHARED_MASK(16'hBFFF)) dut (.mclk(mclk), .resetn(resetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph(periph), .periph_in(periph_in), .pin_in(pin_in), .pad(pad));
    spp_far_model far (.mclk(mclk), .drv(drv), .ext(ext), .pad(pad), .periph(periph),
        .pin_in(pin_in));
    // Clock, and a hang guard far past the sixty or so cycles used
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 5000) begin error_cnt++; finish_test(); end
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin error_cnt++; $display("BAD %s exp %h got %h", nm, exp, got); end
    endtask
    // One transfer; request held until pready is seen high
    task automatic apb(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0000, d};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic t_port();
        apb(0, 8'h00, 0); chk("dir", 16'h7FFF, rd[15:0]);
        chk("oe", 0, pad.oe);
        apb(1, 8'h00, 0); apb(1, 8'h04, 16'hDA5A); apb(0, 8'h04, 0);
        chk("lat", 16'h5A5A, rd[15:0]);
        repeat (2) @(posedge mclk);
        chk("oe", 16'h7FFF, pad.oe);
        chk("dout", 16'h5A5A, pad.dout);
        chk("loop", 16'h0000, periph_in);
        apb(1, 8'h08, 16'hFFFF); apb(0, 8'h04, 0); chk("pinw", 16'h7FFF, rd[15:0]);
    endtask
    task automatic t_own();
        drv <= 16'h4003;
        repeat (4) @(posedge mclk);
        chk("ded", 16'h4000, pad.dout & 16'h4000);
        apb(1, 8'h00, 16'hFFFF); repeat (2) @(posedge mclk);
        chk("own", 16'h0003, pad.oe);
        drv <= 0;
    endtask
    task automatic t_pins();
        ext <= 16'hC3A5; repeat (4) @(posedge mclk);
        apb(0, 8'h08, 0); chk("pin", 16'h43A5, rd[15:0]);
        chk("okerr", 0, {15'h0, er});
        chk("perin", 16'h43A5, periph_in);
        apb(1, 8'h0C, 16'hFFFF); chk("err", 1, {15'h0, er});
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1;
        t_port(); t_own(); t_pins();
        finish_test();
    end
endmodule // tb_shared_pin_parallel_port
